// >>> cfg_header_pkg.sv
// Constants, field layout and timing figures for the configuration header bank
//
// How it works
// [R1] Word zero returns fixed part code high and maker code low, read only.
// [R2] A cleared command half-word leaves only configuration cycles answered.
// [R3] Command bits without a function read zero whatever is written.
// [R4] Address or data parity error sets the detected flag regardless of enables.
// [R5] Driving the system error pin sets the signaled system error flag.
// [R6] Own master transfer ending in master abort sets its flag.
// [R7] Own master transfer ended by target abort sets its flag.
// [R8] Address parity error as target ends in target abort and sets flag.
// [R9] Select timing reads 01; claims are asserted with medium timing.
// [R10] Master parity flag set only with parity response on, on PERR events.
// [R11] Fast back-to-back capability reads one; target accepts such transfers.
// [R12] System error pin is driven only while its enable bit is one.
// [R13] Parity errors are reported only while parity response bit is one.
// [R14] Bus requests and master transfers only while bus master bit is one.
// [R15] Memory accesses claimed only while memory space bit is one.
// [R16] Class code reads fixed 0x040000, a multimedia video device.
// [R17] Low byte of word two is a fixed silicon revision code.
// [R18] Writable latency timer, reset zero; after expiry end when grant removed.
// [R19] Header type byte always reads 0x00.
// [R20] Upper 20 base address bits are writable and place the window.
// [R21] Low 12 base address bits read 0x008: prefetchable 4 KB window.
// [R22] Writing one clears a sticky status flag; writing zero leaves it.
// [R23] Configuration cycle answered only with select high and address bits 00.
// [R24] Writes to fixed or unused bits are dropped; unused bits read zero.
// [R25] Writable bits clear to zero at reset.
// [R26] Memory access claimed when address bits 31 to 12 match the base.

package cfg_header_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_IDENT = 8'h00;
    localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
    localparam logic [7:0] OFS_REV_CLASS = 8'h08;
    localparam logic [7:0] OFS_LAT_HDR = 8'h0C;
    localparam logic [7:0] OFS_WIN_BASE = 8'h10;

    // ----------------------------------------------------------------
    // Command bit positions and writable mask
    // ----------------------------------------------------------------
    localparam int CMD_MEM_EN_BIT = 1;
    localparam int CMD_MASTER_EN_BIT = 2;
    localparam int CMD_PARITY_EN_BIT = 6;
    localparam int CMD_SERR_EN_BIT = 8;
    localparam logic [15:0] CMD_WR_MASK = 16'h0146;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Status: sticky flag index inside the flag vector, and fixed fields
    // ----------------------------------------------------------------
    localparam int FLG_MDPAR = 0;
    localparam int FLG_SIG_TABORT = 1;
    localparam int FLG_RCV_TABORT = 2;
    localparam int FLG_RCV_MABORT = 3;
    localparam int FLG_SIG_SERR = 4;
    localparam int FLG_DET_PERR = 5;
    localparam int NUM_FLAGS = 6;
    localparam logic [1:0] SELECT_TIMING_MEDIUM = 2'h1;
    localparam logic FAST_B2B_CAPABLE = 1'b1;

    // ----------------------------------------------------------------
    // Fixed identification and window fields
    // ----------------------------------------------------------------
    localparam logic [23:0] CLASS_CODE = 24'h040000;
    localparam logic [7:0] HEADER_TYPE = 8'h00;
    localparam logic [7:0] LATENCY_RESET = 8'h00;
    localparam logic [11:0] WIN_LOW_FIXED = 12'h008;
    localparam logic [19:0] WIN_BASE_RESET = 20'h00000;
    localparam int WIN_BASE_LSB = 12;

    // ----------------------------------------------------------------
    // Claim timing: medium select is two clocks after the address phase
    // ----------------------------------------------------------------
    localparam int CLAIM_DELAY_CLOCKS = 2;

endpackage

// >>> host_arbiter.sv
// Bus arbiter model that grants the bank's bus requests
`timescale 1ns/1ps
`default_nettype none
module host_arbiter
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic bus_req,
    output logic gnt_n
);
    // Grant one clock after request; idle is deasserted, never left floating
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            gnt_n <= 1'b1;
        else
            gnt_n <= ~bus_req;
    end
endmodule
`default_nettype wire

// >>> latency_if.sv
// Carrier between the header bank and its latency timer
`timescale 1ns/1ps
`default_nettype none

interface latency_if;
    logic [7:0] timer_value;
    logic burst_start;
    logic burst_active;
    logic expired;
    logic end_burst;

    // Control side: header bank
    modport ctrl (
        output timer_value,
        output burst_start,
        output burst_active,
        input expired,
        input end_burst
    );

    // Timer side
    modport timer (
        input timer_value,
        input burst_start,
        input burst_active,
        output expired,
        output end_burst
    );
endinterface

`default_nettype wire

// >>> master_latency_timer.sv
// Master latency timer with grant pin synchroniser
`timescale 1ns/1ps
`default_nettype none

module master_latency_timer
    import cfg_header_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic gnt_n,
    latency_if.timer lat
);

    logic [7:0] count_reg;
    logic gnt_meta_reg;
    logic gnt_n_sync_reg;

    // ----------------------------------------------------------------
    // Grant pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gnt_meta_reg <= 1'b1;
            gnt_n_sync_reg <= 1'b1;
        end
        else
        begin
            gnt_meta_reg <= gnt_n;
            gnt_n_sync_reg <= gnt_meta_reg;
        end
    end

    // Count down in PCI clocks from the programmed value
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            count_reg <= 8'h00;
        else if (lat.burst_start)
            count_reg <= lat.timer_value; // see [R18]
        else if (lat.burst_active && count_reg != 8'h00)
            count_reg <= count_reg - 8'h01;
    end

    // Expiry alone never ends a burst; the grant must also be gone
    assign lat.expired = lat.burst_active && !lat.burst_start && count_reg == 8'h00;
    assign lat.end_burst = lat.expired && gnt_n_sync_reg; // see [R18]

    // Checked against the pin two edges back, so a broken synchroniser shows up
    a_lat_end_gnt: assert property (@(posedge core_clk) disable iff (!rstn) // see [R18]
        lat.end_burst |-> lat.burst_active && count_reg == 8'h00 && $past(gnt_n, 2))
        else $error("burst ended before expiry or while granted");

endmodule

`default_nettype wire

// >>> pci_config_header_regs.sv
// Type 0 configuration header register bank with enables and error flags
`timescale 1ns/1ps
`default_nettype none

module pci_config_header_regs
    import cfg_header_pkg::*;
#(
    parameter logic [15:0] PART_IDENT = 16'h0A5C, // arbitrary value
    parameter logic [15:0] MAKER_IDENT = 16'h1F2E, // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h03 // arbitrary value
)
(
    input wire logic core_clk,
    input wire logic rstn,
    // Configuration access from the target logic
    input wire logic cfg_valid,
    input wire logic cfg_write,
    input wire logic cfg_idsel,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be_n,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    // Memory target decode
    input wire logic mem_addr_phase,
    input wire logic [31:0] mem_addr,
    input wire logic addr_parity_err,
    input wire logic data_parity_err,
    output logic mem_claim,
    output logic tgt_abort,
    output logic [1:0] select_timing,
    output logic fast_b2b_accept,
    // Master side
    input wire logic master_req,
    input wire logic gnt_n,
    input wire logic burst_start,
    input wire logic burst_active,
    input wire logic master_abort,
    input wire logic target_abort_rcvd,
    input wire logic master_read_perr,
    input wire logic master_write_perr_seen,
    output logic bus_req,
    output logic master_end,
    // Error pins and enables
    input wire logic sys_err_req,
    output logic serr_n_out,
    output logic serr_oe,
    output logic perr_n_out,
    output logic perr_oe,
    output logic mem_space_en,
    output logic bus_master_en,
    output logic parity_resp_en,
    output logic serr_en
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [15:0] cmd_reg;
    logic [NUM_FLAGS-1:0] flags_reg;
    logic [NUM_FLAGS-1:0] flags_set;
    logic [NUM_FLAGS-1:0] flags_clr;
    logic [7:0] latency_reg;
    logic [19:0] win_base_reg;
    logic [31:0] rdata_next;
    logic [15:0] status_word;
    logic cfg_take;
    logic cfg_wr_take;
    logic addr_hit;
    logic claim_stage_reg;
    logic abort_stage_reg;
    logic claim_reg;
    logic tgt_abort_reg;
    logic serr_drive_next;
    logic serr_drive_reg;
    logic perr_drive_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;

    latency_if lat ();

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte lane write strobe; enables are active low on the bus
    function automatic logic lane_wr(input logic [3:0] be_n, input int lane);
        lane_wr = !be_n[lane];
    endfunction

    // Base match on the upper twenty address bits
    function automatic logic base_match(input logic [31:0] addr, input logic [19:0] base);
        base_match = addr[31:WIN_BASE_LSB] == base;
    endfunction

    // ----------------------------------------------------------------
    // Configuration cycle acceptance
    // ----------------------------------------------------------------
    // Anything else is left unclaimed so the host sees a master abort
    assign cfg_take = cfg_valid && cfg_idsel && cfg_addr[1:0] == 2'b00; // see [R23]
    assign cfg_wr_take = cfg_take && cfg_write;

    // Command register: only the four functional bits can ever hold a one
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            cmd_reg <= CMD_RESET; // see [R25]
        else if (cfg_wr_take && cfg_addr == OFS_CMD_STATUS)
        begin
            if (lane_wr(cfg_be_n, 0))
                cmd_reg[7:0] <= cfg_wdata[7:0] & CMD_WR_MASK[7:0]; // see [R3]
            if (lane_wr(cfg_be_n, 1))
                cmd_reg[15:8] <= cfg_wdata[15:8] & CMD_WR_MASK[15:8]; // see [R3]
        end
    end

    assign mem_space_en = cmd_reg[CMD_MEM_EN_BIT];
    assign bus_master_en = cmd_reg[CMD_MASTER_EN_BIT];
    assign parity_resp_en = cmd_reg[CMD_PARITY_EN_BIT];
    assign serr_en = cmd_reg[CMD_SERR_EN_BIT];

    // ----------------------------------------------------------------
    // Sticky status flags
    // ----------------------------------------------------------------
    // Event sources for each flag
    always_comb
    begin
        flags_set = '0;
        flags_set[FLG_DET_PERR] = addr_parity_err || data_parity_err; // see [R4]
        flags_set[FLG_SIG_SERR] = serr_drive_next; // see [R5]
        flags_set[FLG_RCV_MABORT] = master_abort; // see [R6]
        flags_set[FLG_RCV_TABORT] = target_abort_rcvd; // see [R7]
        flags_set[FLG_SIG_TABORT] = abort_stage_reg; // see [R8]
        flags_set[FLG_MDPAR] = parity_resp_en
            && (master_read_perr || master_write_perr_seen); // see [R10]
    end

    // Write-one-to-clear masks; flags live in the top byte lane
    always_comb
    begin
        flags_clr = '0;
        if (cfg_wr_take && cfg_addr == OFS_CMD_STATUS && lane_wr(cfg_be_n, 3))
        begin
            flags_clr[FLG_DET_PERR] = cfg_wdata[31];
            flags_clr[FLG_SIG_SERR] = cfg_wdata[30];
            flags_clr[FLG_RCV_MABORT] = cfg_wdata[29];
            flags_clr[FLG_RCV_TABORT] = cfg_wdata[28];
            flags_clr[FLG_SIG_TABORT] = cfg_wdata[27];
            flags_clr[FLG_MDPAR] = cfg_wdata[24];
        end
    end

    // A set in the clearing cycle wins so no event is lost
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            flags_reg <= '0;
        else
            flags_reg <= (flags_reg & ~flags_clr) | flags_set; // see [R22]
    end

    assign status_word = {flags_reg[FLG_DET_PERR], flags_reg[FLG_SIG_SERR],
        flags_reg[FLG_RCV_MABORT], flags_reg[FLG_RCV_TABORT],
        flags_reg[FLG_SIG_TABORT], SELECT_TIMING_MEDIUM, flags_reg[FLG_MDPAR],
        FAST_B2B_CAPABLE, 7'h00}; // see [R9], [R11]

    // ----------------------------------------------------------------
    // Latency timer and window base
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            latency_reg <= LATENCY_RESET;
        else if (cfg_wr_take && cfg_addr == OFS_LAT_HDR && lane_wr(cfg_be_n, 1))
            latency_reg <= cfg_wdata[15:8]; // see [R18]
    end

    // Low twelve bits are fixed, so writes there are simply dropped
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            win_base_reg <= WIN_BASE_RESET; // see [R25]
        else if (cfg_wr_take && cfg_addr == OFS_WIN_BASE)
        begin
            if (lane_wr(cfg_be_n, 1))
                win_base_reg[3:0] <= cfg_wdata[15:12]; // see [R20]
            if (lane_wr(cfg_be_n, 2))
                win_base_reg[11:4] <= cfg_wdata[23:16]; // see [R20]
            if (lane_wr(cfg_be_n, 3))
                win_base_reg[19:12] <= cfg_wdata[31:24]; // see [R20]
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Whole dword is returned; the host picks its lanes
    always_comb
    begin
        rdata_next = 32'h00000000; // see [R24]
        unique case (cfg_addr)
            OFS_IDENT: rdata_next = {PART_IDENT, MAKER_IDENT}; // see [R1]
            OFS_CMD_STATUS: rdata_next = {status_word, cmd_reg};
            OFS_REV_CLASS: rdata_next = {CLASS_CODE, REVISION_CODE}; // see [R16], [R17]
            OFS_LAT_HDR: rdata_next = {8'h00, HEADER_TYPE, latency_reg, 8'h00}; // see [R19]
            OFS_WIN_BASE: rdata_next = {win_base_reg, WIN_LOW_FIXED}; // see [R21]
            default: rdata_next = 32'h00000000; // see [R24]
        endcase
    end

    // One-cycle answer; writes to unused space are acknowledged too
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg <= cfg_take; // see [R24]
            if (cfg_take && !cfg_write)
                rdata_reg <= rdata_next;
        end
    end

    assign cfg_ack = ack_reg;
    assign cfg_rdata = rdata_reg;

    // ----------------------------------------------------------------
    // Memory target decode
    // ----------------------------------------------------------------
    // Only memory space enabled gives a hit, so a zero command means no claim
    assign addr_hit = mem_addr_phase && mem_space_en
        && base_match(mem_addr, win_base_reg); // see [R2], [R15], [R26]

    // Two-stage pipe gives medium select timing
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            claim_stage_reg <= 1'b0;
            abort_stage_reg <= 1'b0;
            claim_reg <= 1'b0;
            tgt_abort_reg <= 1'b0;
        end
        else
        begin
            claim_stage_reg <= addr_hit; // see [R9]
            abort_stage_reg <= addr_hit && addr_parity_err; // see [R8]
            claim_reg <= claim_stage_reg;
            tgt_abort_reg <= abort_stage_reg;
        end
    end

    assign mem_claim = claim_reg;
    assign tgt_abort = tgt_abort_reg;
    assign select_timing = SELECT_TIMING_MEDIUM;
    // Target decode keeps no idle-cycle requirement between transfers
    assign fast_b2b_accept = FAST_B2B_CAPABLE; // see [R11]

    // ----------------------------------------------------------------
    // Error pin drivers (open drain: enable high while pulling low)
    // ----------------------------------------------------------------
    assign serr_drive_next = serr_en
        && (sys_err_req || (addr_parity_err && parity_resp_en)); // see [R12], [R13]

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serr_drive_reg <= 1'b0;
            perr_drive_reg <= 1'b0;
        end
        else
        begin
            serr_drive_reg <= serr_drive_next; // see [R12]
            perr_drive_reg <= parity_resp_en && data_parity_err; // see [R13]
        end
    end

    assign serr_oe = serr_drive_reg;
    assign serr_n_out = !serr_drive_reg;
    assign perr_oe = perr_drive_reg;
    assign perr_n_out = !perr_drive_reg;

    // ----------------------------------------------------------------
    // Master gating and latency timer
    // ----------------------------------------------------------------
    assign bus_req = master_req && bus_master_en; // see [R14]
    assign lat.timer_value = latency_reg;
    assign lat.burst_start = burst_start && bus_master_en; // see [R14]
    assign lat.burst_active = burst_active;
    assign master_end = lat.end_burst; // see [R18]

    master_latency_timer u_timer (
        .core_clk(core_clk),
        .rstn(rstn),
        .gnt_n(gnt_n),
        .lat(lat.timer)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_ident_read: assert property (@(posedge core_clk) disable iff (!rstn) // see [R1]
        cfg_take && !cfg_write && cfg_addr == OFS_IDENT
        |=> cfg_ack && cfg_rdata == {PART_IDENT, MAKER_IDENT})
        else $error("identity word wrong");

    a_cmd_unused_zero: assert property (@(posedge core_clk) disable iff (!rstn) // see [R3]
        (cmd_reg & ~CMD_WR_MASK) == 16'h0000)
        else $error("unused command bit set");

    a_perr_flag_set: assert property (@(posedge core_clk) disable iff (!rstn) // see [R4]
        addr_parity_err || data_parity_err |=> flags_reg[FLG_DET_PERR])
        else $error("detected parity flag missed");

    a_serr_sets_flag: assert property (@(posedge core_clk) disable iff (!rstn) // see [R5]
        $rose(serr_oe) |-> flags_reg[FLG_SIG_SERR])
        else $error("system error flag not set");

    a_mabort_flag: assert property (@(posedge core_clk) disable iff (!rstn) // see [R6]
        master_abort |=> flags_reg[FLG_RCV_MABORT])
        else $error("master abort flag missed");

    a_tabort_rcv_flag: assert property (@(posedge core_clk) disable iff (!rstn) // see [R7]
        target_abort_rcvd |=> flags_reg[FLG_RCV_TABORT])
        else $error("received target abort flag missed");

    a_addr_perr_abort: assert property (@(posedge core_clk) disable iff (!rstn) // see [R8]
        addr_hit && addr_parity_err |-> ##2 tgt_abort && flags_reg[FLG_SIG_TABORT])
        else $error("address parity error did not abort");

    a_claim_medium: assert property (@(posedge core_clk) disable iff (!rstn) // see [R9]
        addr_hit |=> !mem_claim ##1 mem_claim)
        else $error("claim not at medium timing");

    a_mdpar_gated: assert property (@(posedge core_clk) disable iff (!rstn) // see [R10]
        $rose(flags_reg[FLG_MDPAR]) |-> $past(parity_resp_en))
        else $error("master parity flag set while disabled");

    a_serr_gated: assert property (@(posedge core_clk) disable iff (!rstn) // see [R12]
        serr_oe |-> $past(serr_en) && !serr_n_out)
        else $error("system error driven while disabled");

    a_perr_gated: assert property (@(posedge core_clk) disable iff (!rstn) // see [R13]
        perr_oe |-> $past(parity_resp_en) && $past(data_parity_err))
        else $error("parity reported while disabled");

    a_master_gated: assert property (@(posedge core_clk) disable iff (!rstn) // see [R14]
        bus_req |-> bus_master_en && master_req)
        else $error("bus request while master disabled");

    a_claim_gated: assert property (@(posedge core_clk) disable iff (!rstn) // see [R15]
        mem_claim |-> $past(mem_space_en, 2))
        else $error("claim while memory space disabled");

    a_w1c_clear: assert property (@(posedge core_clk) disable iff (!rstn) // see [R22]
        flags_clr[FLG_RCV_MABORT] && !master_abort |=> !flags_reg[FLG_RCV_MABORT])
        else $error("write one did not clear flag");

    a_cfg_ignored: assert property (@(posedge core_clk) disable iff (!rstn) // see [R23]
        cfg_valid && (!cfg_idsel || cfg_addr[1:0] != 2'b00) |=> !cfg_ack)
        else $error("ignored cycle was answered");

endmodule

`default_nettype wire

// >>> pci_config_header_regs_test.sv
// Self-checking bench for the configuration header bank
`timescale 1ns/1ps
`default_nettype none
module pci_config_header_regs_test;
    import cfg_header_pkg::*;
    logic core_clk, rstn, cfg_valid, cfg_write, cfg_idsel, mem_addr_phase, ape;
    logic master_req, gnt_n, burst_start, burst_active, cfg_ack, mem_claim, tgt_abort;
    logic fast_b2b_accept, bus_req, master_end, serr_en, parity_resp_en;
    logic mem_space_en, bus_master_en, serr_n_out, serr_oe, perr_n_out, perr_oe;
    logic [5:0] evt;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be_n;
    logic [1:0] select_timing;
    logic [31:0] cfg_wdata, mem_addr, rd, cfg_rdata;
    int num_errors = 0;
    int comparisons = 0;
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] rv [6] = '{32'h0A5C1F2E, 32'h02800000, 32'h04000003, 0, 32'h8, 0};

    // Free-running 25 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    pci_config_header_regs pci_config_header_regs_i (.core_clk(core_clk), .rstn(rstn),
        .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_idsel(cfg_idsel),
        .cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .mem_addr_phase(mem_addr_phase), .mem_addr(mem_addr),
        .addr_parity_err(ape), .data_parity_err(evt[0]), .mem_claim(mem_claim),
        .tgt_abort(tgt_abort), .select_timing(select_timing),
        .fast_b2b_accept(fast_b2b_accept), .master_req(master_req), .gnt_n(gnt_n),
        .burst_start(burst_start), .burst_active(burst_active), .master_abort(evt[3]),
        .target_abort_rcvd(evt[2]), .master_read_perr(evt[1]),
        .master_write_perr_seen(evt[5]), .bus_req(bus_req), .master_end(master_end),
        .sys_err_req(evt[4]), .serr_n_out(serr_n_out), .serr_oe(serr_oe), .perr_n_out(perr_n_out),
        .perr_oe(perr_oe), .mem_space_en(mem_space_en), .bus_master_en(bus_master_en),
        .parity_resp_en(parity_resp_en), .serr_en(serr_en));
    host_arbiter host_arbiter_i (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
        .gnt_n(gnt_n));

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // One dword request; ack lands the cycle after the taking edge
    task automatic cfg(input logic w, input logic sel, input logic [7:0] a,
        input logic [3:0] b, input logic [31:0] d, input logic ack);
        @(posedge core_clk);
        {cfg_valid, cfg_write, cfg_idsel} <= {1'b1, w, sel};
        {cfg_addr, cfg_be_n, cfg_wdata} <= {a, b, d};
        @(posedge core_clk);
        cfg_valid <= 1'b0;
        #1;
        chk("cfg_ack", 32'(cfg_ack), 32'(ack));
        rd = cfg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        cfg(1'b0, 1'b1, a, 4'h0, 32'h0, 1'b1);
        chk("cfg_rdata", rd, e);
    endtask
    // Address phase, then claim looked at two cycles later
    task automatic mem(input logic [31:0] a, input logic p, input logic c);
        @(posedge core_clk);
        {mem_addr_phase, mem_addr, ape} <= {1'b1, a, p};
        @(posedge core_clk);
        {mem_addr_phase, ape} <= 2'b00;
        @(posedge core_clk);
        #1;
        chk("mem_claim", 32'(mem_claim), 32'(c));
        chk("tgt_abort", 32'(tgt_abort), 32'(p & c));
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cuts a hang short; the run needs well under a thousand clocks
    initial
    begin
        repeat (3000) @(posedge core_clk);
        num_errors++;
        print_verdict;
    end

    // Main sequence
    initial
    begin
        {rstn, cfg_valid, cfg_write, cfg_idsel, mem_addr_phase, ape, master_req} = '0;
        {burst_start, burst_active, evt, cfg_addr, cfg_be_n, cfg_wdata, mem_addr} = '0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        foreach (ra[i])
            rdc(ra[i], rv[i]);
        $display("test reset values done");
        cfg(1, 1, 8'h04, 4'h0, 32'hFFFFFFFF, 1);
        cfg(1, 1, 8'h10, 4'h0, 32'hABCDE123, 1);
        cfg(1, 1, 8'h0C, 4'h0, 32'hFFFF02FF, 1);
        cfg(1, 1, 8'h00, 4'h0, 32'h0, 1);
        cfg(1, 0, 8'h04, 4'h0, 32'h0, 0);
        cfg(1, 1, 8'h05, 4'h0, 32'h0, 0);
        rdc(8'h04, 32'h02800146);
        rdc(8'h0C, 32'h00000200);
        rdc(8'h10, 32'hABCDE008);
        rdc(8'h00, 32'h0A5C1F2E);
        chk("en", 32'({serr_en, parity_resp_en, bus_master_en, mem_space_en}), 32'hF);
        $display("test register writes done");
        mem(32'hABCDF000, 0, 0);
        mem(32'hABCDE010, 0, 1);
        chk("timing", 32'({fast_b2b_accept, select_timing}), 32'h5);
        mem(32'hABCDEFFC, 1, 1);
        rdc(8'h04, 32'hCA800146);
        cfg(1, 1, 8'h04, 4'h7, 32'hFF000000, 1);
        rdc(8'h04, 32'h02800146);
        $display("test memory decode done");
        // Master parity comes from the write path here, pins are driven one cycle
        @(posedge core_clk);
        evt <= 6'h3D;
        @(posedge core_clk);
        evt <= 6'h00;
        #1;
        chk("err_pins", 32'({serr_oe, serr_n_out, perr_oe, perr_n_out}), 32'hA);
        rdc(8'h04, 32'hF3800146);
        cfg(1, 1, 8'h04, 4'h7, 32'h10000000, 1);
        rdc(8'h04, 32'hE3800146);
        $display("test status flags done");
        @(posedge core_clk);
        master_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("bus_req", 32'({bus_req, gnt_n}), 32'h2);
        {burst_start, burst_active} <= 2'b11;
        @(posedge core_clk);
        burst_start <= 1'b0;
        // Timer has run out but grant is still held: no end yet
        repeat (6) @(posedge core_clk);
        chk("master_end", 32'(master_end), 32'h0);
        master_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("master_end", 32'(master_end), 32'h1);
        burst_active <= 1'b0;
        $display("test latency done");
        cfg(1, 1, 8'h04, 4'h0, 32'hFF000000, 1);
        mem(32'hABCDE010, 0, 0);
        // With every enable off only the detected parity flag may move
        @(posedge core_clk);
        {master_req, evt} <= {1'b1, 6'h13};
        @(posedge core_clk);
        evt <= 6'h00;
        #1;
        chk("bus_req", 32'(bus_req), 32'h0);
        chk("err_pins", 32'({serr_oe, serr_n_out, perr_oe, perr_n_out}), 32'h5);
        rdc(8'h04, 32'h82800000);
        $display("test command zero done");
        print_verdict;
    end
endmodule
`default_nettype wire
